/* inc/tac_pkg.sv */
package tac_pkg;
  localparam int CLK_HZ = 25000000;
  localparam int CLK_PERIOD_PS = 40000;
  localparam int TS_SEL_W = 4;
  localparam logic [3:0] TS_OFF = 4'h0;
  localparam logic [3:0] TS_125NS = 4'h1;
  localparam logic [3:0] TS_250NS = 4'h2;
  localparam logic [3:0] TS_500NS = 4'h3;
  localparam logic [3:0] TS_1US = 4'h4;
  localparam logic [3:0] TS_2US = 4'h5;
  localparam logic [3:0] TS_4US = 4'h6;
  localparam logic [3:0] TS_8US = 4'h7;
  localparam logic [3:0] TS_16US = 4'h8;
  localparam logic [3:0] TS_100US = 4'h9;
  localparam int TICK_125NS_PS = 125000;
  localparam int TICK_100US_PS = 100000000;
  localparam int CYC_125NS = (TICK_125NS_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int CYC_100US = TICK_100US_PS / CLK_PERIOD_PS;
  localparam int TS_W = 32;
  localparam int ADDR_W = 24;
  localparam int DATA_W = 16;
  localparam int NUM_EVT = 10;
  localparam int NUM_RANGE = 4;
  localparam int CYC_TYPES = 8;
  localparam int IDX_W = 16;
  localparam int FIFO_DEPTH = 16;
  localparam logic [11:0] PADDR_CTRL = 12'h000;
  localparam logic [11:0] PADDR_START_MASK = 12'h004;
  localparam logic [11:0] PADDR_HALT_MASK = 12'h008;
  localparam logic [11:0] PADDR_EVT_VALID = 12'h00c;
  localparam logic [11:0] PADDR_STATUS = 12'h010;
  localparam logic [11:0] PADDR_TSTAMP = 12'h014;
  localparam logic [11:0] PADDR_INDEX = 12'h018;
  localparam logic [11:0] PADDR_RANGE_EN = 12'h01c;
  localparam int CTRL_TS_LSB = 0;
  localparam int CTRL_FREE_BIT = 4;
  localparam int CTRL_SUPP_LSB = 8;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
    logic wr;
    logic [2:0] cyc_type;
    logic [2:0] area;
    logic [3:0] clocks;
    logic [3:0] probes;
    logic nmi;
    logic [7:0] irq;
  } tac_bus_s;

  typedef struct packed {
    logic [IDX_W-1:0] index;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
    logic wr;
    logic ts_mode;
    logic [TS_W-1:0] extra;
  } tac_rec_s;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ARMED = 2'b01,
    ST_CAPTURE = 2'b10,
    ST_HALTED = 2'b11
  } tac_state_e;
endpackage

/* src/tac_fifo.sv */
`timescale 1ns/1ps
module tac_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] cnt_q;
  logic push;
  logic pop;

  assign in_ready = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem[rd_q];

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_q] <= in_data;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= rd_q + 1'b1;
      end
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule // tac_fifo

/* src/tac_tick_gen.sv */
`timescale 1ns/1ps
module tac_tick_gen
  import tac_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic clr,
  input wire logic [TS_SEL_W-1:0] sel,
  output logic tick
);
  logic [6:0] base_cnt_q;
  logic base_tick;
  logic [3:0] mul_cnt_q;
  logic [11:0] long_cnt_q;
  logic [3:0] mul;

  always_comb begin
    case (sel)
      TS_125NS: mul = 4'h1;
      TS_250NS: mul = 4'h2;
      TS_500NS: mul = 4'h4;
      TS_1US: mul = 4'h8;
      default: mul = 4'h0;
    endcase
  end

  assign base_tick = (base_cnt_q == 7'(CYC_125NS - 1));

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      base_cnt_q <= 7'h00;
    end else if (clr || base_tick) begin
      base_cnt_q <= 7'h00;
    end else begin
      base_cnt_q <= base_cnt_q + 7'h01;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mul_cnt_q <= 4'h0;
      long_cnt_q <= 12'h000;
      tick <= 1'b0;
    end else begin
      tick <= 1'b0;
      if (clr || sel == TS_OFF) begin
        mul_cnt_q <= 4'h0;
        long_cnt_q <= 12'h000;
      end else if (sel == TS_100US) begin
        if (long_cnt_q == 12'(CYC_100US - 1)) begin
          long_cnt_q <= 12'h000;
          tick <= 1'b1;
        end else begin
          long_cnt_q <= long_cnt_q + 12'h001;
        end
      end else if (sel == TS_2US || sel == TS_4US || sel == TS_8US || sel == TS_16US) begin
        if (long_cnt_q == 12'(((CYC_125NS * 16) << (sel - TS_2US)) - 1)) begin
          long_cnt_q <= 12'h000;
          tick <= 1'b1;
        end else begin
          long_cnt_q <= long_cnt_q + 12'h001;
        end
      end else if (base_tick) begin
        if (mul_cnt_q == mul - 4'h1) begin
          mul_cnt_q <= 4'h0;
          tick <= 1'b1;
        end else begin
          mul_cnt_q <= mul_cnt_q + 4'h1;
        end
      end
    end
  end
endmodule // tac_tick_gen

/* src/tac_top.sv */
// Summary of operation
// - Time-stamp tick is selectable as off or 160 ns, 320 ns, 640 ns, 1.28 us, 2.56 us, 5.12 us, 10.24 us, 20.48 us or 100 us.
// - The 32-bit time-stamp counter steps once per selected tick.
// - On overflow the counter wraps to zero and capture continues.
// - With time stamping off no time stamp value enters any record.
// - Bus cycles of a suppressed type make no record.
// - Free-running capture records from the moment the program starts, needing no start event.
// - In free-running capture only halt events count and the four range channels are off.
// - Without free-running capture, recording starts and halts only on the configured events.
// - With time stamping on a record keeps index, address, data, direction and stamp only.
// - Removing an event point that a range or stop function uses disables that function.
// - When the trace buffer is full each new record overwrites the oldest.
// - The time-stamp counter restarts from zero whenever the program starts.
`timescale 1ns/1ps
module tac_top
  import tac_pkg::*;
#(
  parameter int BUF_DEPTH = 256
) (
  input wire logic CLK,
  input wire logic RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic PROG_START,
  input wire logic PROG_STOP,
  input wire logic BUS_VALID,
  input wire tac_pkg::tac_bus_s BUS_CYCLE,
  input wire logic [NUM_EVT-1:0] EVT_HIT,
  output logic [NUM_RANGE-1:0] RANGE_EN,
  output logic CAPTURING,
  input wire logic [$clog2(BUF_DEPTH)-1:0] BUF_RADDR,
  output tac_pkg::tac_rec_s BUF_RDATA
);
  import tac_pkg::*;
  localparam int BAW = $clog2(BUF_DEPTH);
  localparam int RW = $bits(tac_rec_s);

  logic [31:0] ctrl_q;
  logic [NUM_EVT-1:0] start_mask_q;
  logic [NUM_EVT-1:0] halt_mask_q;
  logic [NUM_EVT-1:0] evt_valid_q;
  logic [NUM_RANGE-1:0] range_req_q;
  tac_state_e state_q;
  tac_state_e state_d;
  logic [TS_W-1:0] ts_q;
  logic [IDX_W-1:0] idx_q;
  logic [BAW-1:0] wptr_q;
  logic wrapped_q;
  logic ts_tick;
  logic [TS_SEL_W-1:0] ts_sel;
  logic free_mode;
  logic [CYC_TYPES-1:0] supp;
  logic start_hit;
  logic halt_hit;
  logic take;
  tac_rec_s rec;
  logic fifo_ready;
  logic fifo_valid;
  logic [RW-1:0] fifo_data;
  tac_rec_s buf_mem [BUF_DEPTH];
  logic apb_wr;
  logic apb_rd;
  logic ts_on;
  logic lost_q;
  logic ts_wrap_q;
  logic [31:0] rdata_d;

  assign ts_sel = ctrl_q[CTRL_TS_LSB +: TS_SEL_W];
  assign free_mode = ctrl_q[CTRL_FREE_BIT];
  assign supp = ctrl_q[CTRL_SUPP_LSB +: CYC_TYPES];
  assign ts_on = (ts_sel != TS_OFF) && (ts_sel <= TS_100US);
  assign apb_wr = PSEL && PENABLE && PWRITE;
  assign apb_rd = PSEL && PENABLE && !PWRITE;
  assign PREADY = 1'b1;

  always_comb begin
    PSLVERR = 1'b0;
    if (PSEL && PENABLE) begin
      case (PADDR)
        PADDR_CTRL, PADDR_START_MASK, PADDR_HALT_MASK, PADDR_EVT_VALID,
        PADDR_STATUS, PADDR_TSTAMP, PADDR_INDEX, PADDR_RANGE_EN: PSLVERR = 1'b0;
        default: PSLVERR = 1'b1;
      endcase
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      ctrl_q <= CTRL_RESET;
      start_mask_q <= '0;
      halt_mask_q <= '0;
      evt_valid_q <= '0;
      range_req_q <= '0;
    end else if (apb_wr) begin
      case (PADDR)
        PADDR_CTRL: ctrl_q <= PWDATA;
        PADDR_START_MASK: start_mask_q <= PWDATA[NUM_EVT-1:0] & evt_valid_q;
        PADDR_HALT_MASK: halt_mask_q <= PWDATA[NUM_EVT-1:0] & evt_valid_q;
        PADDR_EVT_VALID: begin
          evt_valid_q <= PWDATA[NUM_EVT-1:0];
          start_mask_q <= start_mask_q & PWDATA[NUM_EVT-1:0];
          if ((halt_mask_q & ~PWDATA[NUM_EVT-1:0]) != '0) begin
            halt_mask_q <= '0;
          end
          if ((start_mask_q & ~PWDATA[NUM_EVT-1:0]) != '0) begin
            range_req_q <= '0;
          end
        end
        PADDR_RANGE_EN: begin
          if (evt_valid_q != '0) begin
            range_req_q <= PWDATA[NUM_RANGE-1:0];
          end
        end
        default: begin
        end
      endcase
    end
  end

  always_comb begin
    case (PADDR)
      PADDR_CTRL: rdata_d = ctrl_q;
      PADDR_START_MASK: rdata_d = 32'(start_mask_q);
      PADDR_HALT_MASK: rdata_d = 32'(halt_mask_q);
      PADDR_EVT_VALID: rdata_d = 32'(evt_valid_q);
      PADDR_STATUS: rdata_d = {27'h0000000, ts_wrap_q, lost_q, wrapped_q, state_q};
      PADDR_TSTAMP: rdata_d = ts_q;
      PADDR_INDEX: rdata_d = 32'(idx_q);
      PADDR_RANGE_EN: rdata_d = 32'(RANGE_EN);
      default: rdata_d = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      PRDATA <= 32'h0000_0000;
    end else if (PSEL && !PENABLE && !PWRITE) begin
      PRDATA <= rdata_d;
    end
  end

  assign RANGE_EN = free_mode ? '0 : range_req_q;

  tac_tick_gen u_tick (
    .clk(CLK),
    .rst(RST),
    .clr(PROG_START),
    .sel(ts_sel),
    .tick(ts_tick)
  );

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      ts_q <= '0;
    end else if (PROG_START) begin
      ts_q <= '0;
    end else if (ts_tick && ts_on) begin
      ts_q <= ts_q + 32'h0000_0001;
    end
  end

  assign start_hit = (EVT_HIT & start_mask_q) != '0;
  assign halt_hit = (EVT_HIT & halt_mask_q) != '0;

  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (PROG_START) begin
          state_d = free_mode ? ST_CAPTURE : ST_ARMED;
        end
      end
      ST_ARMED: begin
        if (PROG_STOP) begin
          state_d = ST_IDLE;
        end else if (PROG_START) begin
          state_d = free_mode ? ST_CAPTURE : ST_ARMED;
        end else if (!free_mode && start_hit) begin
          state_d = ST_CAPTURE;
        end
      end
      ST_CAPTURE: begin
        if (PROG_STOP) begin
          state_d = ST_IDLE;
        end else if (PROG_START) begin
          state_d = free_mode ? ST_CAPTURE : ST_ARMED;
        end else if (halt_hit) begin
          state_d = ST_HALTED;
        end
      end
      ST_HALTED: begin
        if (PROG_STOP) begin
          state_d = ST_IDLE;
        end else if (PROG_START) begin
          state_d = free_mode ? ST_CAPTURE : ST_ARMED;
        end
      end
      default: state_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      state_q <= ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  assign CAPTURING = (state_q == ST_CAPTURE);
  assign take = CAPTURING && BUS_VALID && !supp[BUS_CYCLE.cyc_type] && !halt_hit;

  always_comb begin
    rec.index = idx_q;
    rec.addr = BUS_CYCLE.addr;
    rec.data = BUS_CYCLE.data;
    rec.wr = BUS_CYCLE.wr;
    rec.ts_mode = ts_on;
    if (ts_on) begin
      rec.extra = ts_q;
    end else begin
      rec.extra = {BUS_CYCLE.area, BUS_CYCLE.cyc_type, BUS_CYCLE.clocks, BUS_CYCLE.probes,
                   BUS_CYCLE.nmi, BUS_CYCLE.irq, 9'h000};
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      idx_q <= '0;
    end else if (PROG_START) begin
      idx_q <= '0;
    end else if (take && fifo_ready) begin
      idx_q <= idx_q + 16'h0001;
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      lost_q <= 1'b0;
    end else if (take && !fifo_ready) begin
      lost_q <= 1'b1;
    end else if (PROG_START) begin
      lost_q <= 1'b0;
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      ts_wrap_q <= 1'b0;
    end else if (ts_tick && ts_on && ts_q == '1) begin
      ts_wrap_q <= 1'b1;
    end else if (PROG_START) begin
      ts_wrap_q <= 1'b0;
    end
  end

  tac_fifo #(
    .WIDTH(RW),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(CLK),
    .rst(RST),
    .in_valid(take),
    .in_ready(fifo_ready),
    .in_data(rec),
    .out_valid(fifo_valid),
    .out_ready(1'b1),
    .out_data(fifo_data)
  );

  always_ff @(posedge CLK) begin
    if (fifo_valid) begin
      buf_mem[wptr_q] <= tac_rec_s'(fifo_data);
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      wptr_q <= '0;
      wrapped_q <= 1'b0;
    end else if (fifo_valid) begin
      wptr_q <= wptr_q + 1'b1;
      if (wptr_q == BAW'(BUF_DEPTH - 1)) begin
        wrapped_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      BUF_RDATA <= '0;
    end else begin
      BUF_RDATA <= buf_mem[BUF_RADDR];
    end
  end
endmodule // tac_top

/* tb/tac_bus_model.sv */
`timescale 1ns/1ps
module tac_bus_model
  import tac_pkg::*;
(
  input wire logic clk,
  output logic bus_valid,
  output tac_pkg::tac_bus_s bus_cycle
);
  initial begin
    bus_valid = 1'b0;
    bus_cycle = '0;
  end
  // Outside a cycle the bus shows the inverse of its last value.
  task automatic send(input tac_bus_s c);
    @(posedge clk);
    bus_valid <= 1'b1;
    bus_cycle <= c;
    @(posedge clk);
    bus_valid <= 1'b0;
    bus_cycle <= ~c;
  endtask
endmodule // tac_bus_model

/* tb/tac_checker.sv */
`timescale 1ns/1ps
module tac_checker
  import tac_pkg::*;
(
  input wire logic CLK,
  input wire logic RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  input wire logic PROG_START,
  input wire logic PROG_STOP,
  input wire logic [NUM_EVT-1:0] EVT_HIT,
  input wire logic [NUM_RANGE-1:0] RANGE_EN,
  input wire logic CAPTURING
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);
  logic free_q;
  logic unmap;
  logic rsetup;
  assign unmap = PADDR > PADDR_RANGE_EN || PADDR[1:0] != 2'h0;
  assign rsetup = PSEL && !PENABLE && !PWRITE;
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      free_q <= 1'b0;
    end else if (PSEL && PENABLE && PWRITE && PADDR == PADDR_CTRL) begin
      free_q <= PWDATA[CTRL_FREE_BIT];
    end
  end
  a_ready_high: assert property (PREADY)
    else $error("pready low");
  a_err_unmapped: assert property (PSEL && PENABLE && unmap |-> PSLVERR)
    else $error("no error on unmapped access");
  a_err_mapped: assert property (PSEL && PENABLE && !unmap |-> !PSLVERR)
    else $error("error on mapped access");
  a_read_zero: assert property (rsetup && unmap |=> (PRDATA == 32'h0) [*2])
    else $error("unmapped read not zero");
  a_rdata_hold: assert property (!rsetup |=> $stable(PRDATA))
    else $error("read data moved");
  a_free_range: assert property (free_q |-> RANGE_EN == 4'h0)
    else $error("range channel on in free mode");
  a_free_start: assert property (free_q && PROG_START && !PROG_STOP && EVT_HIT == '0 |=> CAPTURING)
    else $error("free capture did not start");
  a_armed_wait: assert property (!free_q && !CAPTURING && PROG_START && !PROG_STOP && EVT_HIT == '0 |=> !CAPTURING)
    else $error("capture without start event");
  a_stop_idle: assert property (PROG_STOP |=> !CAPTURING)
    else $error("capture after program stop");
  cover property (free_q && PROG_START);
  cover property (PSEL && PENABLE && unmap);
  cover property ($fell(CAPTURING));
endmodule // tac_checker

/* tb/tb.sv */
`timescale 1ns/1ps
module tb;
  import tac_pkg::*;
  logic CLK = 1'b0;
  logic RST = 1'b1;
  logic PSEL = 1'b0;
  logic PENABLE = 1'b0;
  logic PWRITE = 1'b0;
  logic [11:0] PADDR = 12'h000;
  logic [31:0] PWDATA = 32'h0;
  logic [31:0] PRDATA;
  logic PREADY;
  logic PSLVERR;
  logic PROG_START = 1'b0;
  logic PROG_STOP = 1'b0;
  logic BUS_VALID;
  tac_bus_s BUS_CYCLE;
  logic [NUM_EVT-1:0] EVT_HIT = '0;
  logic [NUM_RANGE-1:0] RANGE_EN;
  logic CAPTURING;
  logic [2:0] BUF_RADDR = 3'h0;
  tac_rec_s BUF_RDATA;
  tac_rec_s rec;
  logic [31:0] r;
  logic [31:0] t0;
  logic e;
  int n_mismatch = 0;
  int checks_done = 0;
  always #20 CLK = ~CLK;
  tac_top #(.BUF_DEPTH(8)) i_dut (.CLK(CLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
    .PSLVERR(PSLVERR), .PROG_START(PROG_START), .PROG_STOP(PROG_STOP), .BUS_VALID(BUS_VALID),
    .BUS_CYCLE(BUS_CYCLE), .EVT_HIT(EVT_HIT), .RANGE_EN(RANGE_EN), .CAPTURING(CAPTURING),
    .BUF_RADDR(BUF_RADDR), .BUF_RDATA(BUF_RDATA));
  tac_bus_model i_bus (.clk(CLK), .bus_valid(BUS_VALID), .bus_cycle(BUS_CYCLE));
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] x);
    checks_done++;
    if (s !== x) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", n, x, s);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge CLK);
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    PSEL <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLK);
    PENABLE <= 1'b1;
    do @(posedge CLK); while (PREADY !== 1'b1);
    r = PRDATA;
    e = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    @(posedge CLK);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] x, input string n);
    apb(1'b0, a, 32'h0);
    chk(n, r, x);
  endtask
  task automatic rbuf(input int i);
    BUF_RADDR <= i[2:0];
    tick(2);
    rec = BUF_RDATA;
  endtask
  function automatic tac_bus_s mk(input logic [23:0] a, input logic [2:0] t);
    mk = '{addr: a, data: a[15:0] ^ 16'h5a5a, wr: a[0], cyc_type: t, area: 3'h5,
      clocks: 4'h2, probes: 4'ha, nmi: 1'b1, irq: 8'h3c};
  endfunction
  task automatic end_sim;
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    #1200000;
    n_mismatch++;
    end_sim();
  end
  initial begin
    tick(12);
    RST <= 1'b0;
    tick(1);
    rd(PADDR_CTRL, 32'h0, "ctrl reset");
    rd(PADDR_STATUS, 32'h0, "status reset");
    rd(12'h020, 32'h0, "unmapped read");
    chk("unmapped error", e, 1);
    for (int i = 0; i < 10; i++) begin
      apb(1'b1, PADDR_CTRL, i);
      rd(PADDR_CTRL, i, "tick select");
    end
    apb(1'b1, PADDR_EVT_VALID, 32'h1);
    apb(1'b1, PADDR_HALT_MASK, 32'h1);
    apb(1'b1, PADDR_CTRL, 32'h0810);
    PROG_START <= 1'b1;
    tick(1);
    PROG_START <= 1'b0;
    tick(1);
    chk("free start", CAPTURING, 1);
    chk("range off", RANGE_EN, 0);
    for (int i = 0; i < 9; i++) begin
      if (i == 5) i_bus.send(mk(24'hdead, 3'h3));
      i_bus.send(mk(24'h100 + i, 3'h1));
    end
    tick(4);
    for (int i = 0; i < 8; i++) begin
      rbuf(i);
      chk("record addr", rec.addr, 24'h100 + (i == 0 ? 8 : i));
    end
    chk("plain extra", rec.extra, {3'h5, 3'h1, 4'h2, 4'ha, 1'b1, 8'h3c, 9'h0});
    chk("plain flag", rec.ts_mode, 0);
    rd(PADDR_STATUS, 32'h6, "status wrapped");
    EVT_HIT <= 10'h001;
    tick(1);
    EVT_HIT <= '0;
    tick(1);
    chk("halted", CAPTURING, 0);
    PROG_STOP <= 1'b1;
    tick(1);
    PROG_STOP <= 1'b0;
    apb(1'b1, PADDR_CTRL, 32'h1);
    apb(1'b1, PADDR_EVT_VALID, 32'h3);
    apb(1'b1, PADDR_START_MASK, 32'h2);
    apb(1'b1, PADDR_RANGE_EN, 32'hf);
    chk("range on", RANGE_EN, 4'hf);
    PROG_START <= 1'b1;
    tick(1);
    PROG_START <= 1'b0;
    tick(1);
    chk("armed", CAPTURING, 0);
    apb(1'b0, PADDR_TSTAMP, 32'h0);
    t0 = r;
    tick(37);
    rd(PADDR_TSTAMP, t0 + 32'd10, "stamp step");
    chk("stamp restart", t0 < 3, 1);
    EVT_HIT <= 10'h002;
    tick(1);
    EVT_HIT <= '0;
    tick(1);
    chk("started", CAPTURING, 1);
    i_bus.send(mk(24'h77, 3'h1));
    tick(4);
    rbuf(1);
    chk("stamped addr", rec.addr, 24'h77);
    chk("stamped flag", rec.ts_mode, 1);
    chk("stamped index", rec.index, 0);
    apb(1'b1, PADDR_HALT_MASK, 32'h3);
    apb(1'b1, PADDR_EVT_VALID, 32'h1);
    chk("range dropped", RANGE_EN, 0);
    rd(PADDR_HALT_MASK, 32'h0, "stop dropped");
    end_sim();
  end
endmodule // tb
bind tac_top tac_checker i_chk (.CLK(CLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE),
  .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
  .PSLVERR(PSLVERR), .PROG_START(PROG_START), .PROG_STOP(PROG_STOP), .EVT_HIT(EVT_HIT),
  .RANGE_EN(RANGE_EN), .CAPTURING(CAPTURING));
